// ===== pkg/pwg_defs.svh
// constants for the parameter write guard
`ifndef PWG_DEFS_SVH
`define PWG_DEFS_SVH
`define PWG_FAULT_CODE        8'h31
`define PWG_FAULT_NONE        8'h00
`define PWG_ST_NOT_READY      4'h0
`define PWG_ST_SW_ON_DISABLED 4'h2
`define PWG_ST_READY_SW_ON    4'h3
`define PWG_ST_FAULT          4'hE
`define PWG_ADDR_W            8
`define PWG_DATA_W            16
`define PWG_STATE_W           4
`endif

// ===== pkg/pwg_mem_if.sv
// write and read port between the guard and its parameter store
`timescale 1ns/10ps
interface pwg_mem_if #(parameter int AW = 8, parameter int DW = 16);
	logic          wrEn;
	logic [AW-1:0] wrAddr;
	logic [DW-1:0] wrData;
	logic [AW-1:0] rdAddr;
	logic [DW-1:0] rdData;
	modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
	modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : pwg_mem_if

// ===== pkg/pwg_pkg.sv
// types shared by the parameter write guard
package pwg_pkg;
	typedef enum logic {PWG_SRC_CAN, PWG_SRC_SERIAL} pwg_src_t;
	typedef enum logic [1:0] {PWG_RSP_NONE, PWG_RSP_DONE, PWG_RSP_ABORT} pwg_rsp_t;
endpackage : pwg_pkg

// ===== rtl/pwg_guard.sv
// parameter write guard: arbitrates CAN and serial writes, applies attributes
`timescale 1ns/10ps
`include "pwg_defs.svh"

// Overview of operation
// (R1) CAN and serial ports each read and write every parameter independently.
// (R2) writing a change-fault parameter raises fault code 49.
// (R3) attribute handling is identical for CAN and serial writes.
// (R4) the change fault stays latched; only power cycling (reset) clears it.
// (R5) idle-only parameters accept writes only in states 0, 2, 3 or 14.
// (R6) idle-only write outside those states gets an abort response.
// (R7) aborted writes leave stored value unchanged and cause no side effect.
// (R8) ordinary or permitted writes are stored with no fault and no abort.
module pwg_guard
	import pwg_pkg::*;
#(
	parameter int AW = `PWG_ADDR_W,
	parameter int DW = `PWG_DATA_W,
	parameter int SW = `PWG_STATE_W
) (
	input  wire logic          clock,
	input  wire logic          nrst,
	input  wire logic [SW-1:0] deviceState,
	input  wire logic          canReq,
	input  wire logic          canWrite,
	input  wire logic [AW-1:0] canAddr,
	input  wire logic [DW-1:0] canWrData,
	output logic               canAck,
	output pwg_pkg::pwg_rsp_t  canRsp,
	output logic [DW-1:0]      canRdData,
	input  wire logic          serReq,
	input  wire logic          serWrite,
	input  wire logic [AW-1:0] serAddr,
	input  wire logic [DW-1:0] serWrData,
	output logic               serAck,
	output pwg_pkg::pwg_rsp_t  serRsp,
	output logic [DW-1:0]      serRdData,
	input  wire logic          changeFaultAttr,
	input  wire logic          idleOnlyAttr,
	output logic [AW-1:0]      attrAddr,
	output logic               paramChangeFault,
	output logic [7:0]         faultCode
);
	import pwg_pkg::*;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rstSync1_q, rstSync2_q;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rstSync1_q <= 1'b0;
			rstSync2_q <= 1'b0;
		end else begin
			rstSync1_q <= 1'b1;
			rstSync2_q <= rstSync1_q;
		end
	end
	wire rstN = rstSync2_q;

	// ----------------------------------------
	// port arbitration
	// ----------------------------------------
	// one request per cycle; a request is served in the cycle it is seen, so
	// the losing port simply waits with its request held
	logic lastSer_q;
	logic canPend_q, serPend_q;
	// a port whose answer still stands is not granted again, so a requester that
	// holds its request up to the edge where it sees the ack is served only once
	wire  canReqV   = canReq && !canPend_q;
	wire  serReqV   = serReq && !serPend_q;
	wire  grantSer  = serReqV && (!canReqV || !lastSer_q);  // R1
	wire  grantCan  = canReqV && !grantSer;                 // R1
	wire  anyGrant  = grantSer || grantCan;
	wire  selWrite  = grantSer ? serWrite : canWrite;
	wire [AW-1:0] selAddr = grantSer ? serAddr : canAddr;
	wire [DW-1:0] selData = grantSer ? serWrData : canWrData;
	pwg_src_t selSrc;
	assign selSrc   = grantSer ? PWG_SRC_SERIAL : PWG_SRC_CAN;
	assign attrAddr = selAddr;

	// ----------------------------------------
	// attribute decision
	// ----------------------------------------
	// the decision does not look at the source port at all
	wire stateIdle = (deviceState == `PWG_ST_NOT_READY)
		|| (deviceState == `PWG_ST_SW_ON_DISABLED)
		|| (deviceState == `PWG_ST_READY_SW_ON)
		|| (deviceState == `PWG_ST_FAULT);                 // R5
	wire isWrite   = anyGrant && selWrite;                 // R3
	wire refuse    = isWrite && idleOnlyAttr && !stateIdle; // R6
	wire accept    = isWrite && !refuse;                   // R8
	wire raiseFlt  = accept && changeFaultAttr;            // R2

	// ----------------------------------------
	// parameter store
	// ----------------------------------------
	pwg_mem_if #(.AW(AW), .DW(DW)) memBus ();
	assign memBus.wrEn   = accept;                         // R7
	assign memBus.wrAddr = selAddr;
	assign memBus.wrData = selData;
	assign memBus.rdAddr = selAddr;

	pwg_param_mem #(.AW(AW), .DW(DW)) uMem (
		.clock (clock),
		.port  (memBus.mem)
	);

	// ----------------------------------------
	// responses
	// ----------------------------------------
	// read data leave the store one cycle after the request, so responses for
	// both reads and writes are given one cycle after the grant
	pwg_rsp_t rsp_q;
	logic     fault_q;

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			lastSer_q <= 1'b0;
			canPend_q <= 1'b0;
			serPend_q <= 1'b0;
			rsp_q     <= PWG_RSP_NONE;
		end else begin
			if (anyGrant) begin
				lastSer_q <= (selSrc == PWG_SRC_SERIAL);
			end
			canPend_q <= grantCan;
			serPend_q <= grantSer;
			rsp_q     <= refuse ? PWG_RSP_ABORT : PWG_RSP_DONE; // R6
		end
	end

	// latched until reset; no other path clears it
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			fault_q <= 1'b0;
		end else if (raiseFlt) begin
			fault_q <= 1'b1;                                   // R4
		end
	end

	assign canAck           = canPend_q;
	assign serAck           = serPend_q;
	assign canRsp           = canPend_q ? rsp_q : PWG_RSP_NONE;
	assign serRsp           = serPend_q ? rsp_q : PWG_RSP_NONE;
	assign canRdData        = memBus.rdData;
	assign serRdData        = memBus.rdData;
	assign paramChangeFault = fault_q;
	assign faultCode        = fault_q ? `PWG_FAULT_CODE : `PWG_FAULT_NONE; // R2

	// ----------------------------------------
	// checks: faults and attributes
	// ----------------------------------------
	chk_fault_raise: assert property (@(posedge clock) disable iff (!rstN) // R2
		raiseFlt |=> paramChangeFault && faultCode == `PWG_FAULT_CODE)
		else $error("change fault not raised after write");
	chk_fault_sticky: assert property (@(posedge clock) disable iff (!rstN) // R4
		paramChangeFault |=> paramChangeFault)
		else $error("change fault cleared without reset");
	chk_fault_cause: assert property (@(posedge clock) disable iff (!rstN) // R2
		$rose(paramChangeFault) |-> $past(accept) && $past(changeFaultAttr))
		else $error("change fault raised without a write");
	chk_fault_code_zero: assert property (@(posedge clock) disable iff (!rstN) // R2
		!paramChangeFault |-> faultCode == `PWG_FAULT_NONE)
		else $error("fault code shown without a fault");
	chk_abort_state: assert property (@(posedge clock) disable iff (!rstN) // R6
		isWrite && idleOnlyAttr
		&& !(deviceState inside {`PWG_ST_NOT_READY, `PWG_ST_SW_ON_DISABLED,
			`PWG_ST_READY_SW_ON, `PWG_ST_FAULT})
		|=> rsp_q == PWG_RSP_ABORT)
		else $error("write in busy state not aborted");
	chk_idle_accept: assert property (@(posedge clock) disable iff (!rstN) // R5
		isWrite && deviceState inside {`PWG_ST_NOT_READY, `PWG_ST_SW_ON_DISABLED,
			`PWG_ST_READY_SW_ON, `PWG_ST_FAULT} |-> memBus.wrEn)
		else $error("idle state write not stored");
	// a refused write must reach neither the store nor the fault latch
	chk_abort_nowrite: assert property (@(posedge clock) disable iff (!rstN) // R7
		refuse |-> !memBus.wrEn && !raiseFlt)
		else $error("aborted write had an effect");
	chk_abort_nofault: assert property (@(posedge clock) disable iff (!rstN) // R7
		refuse && !paramChangeFault |=> !paramChangeFault)
		else $error("aborted write raised the change fault");
	chk_plain_write: assert property (@(posedge clock) disable iff (!rstN) // R8
		isWrite && !idleOnlyAttr && !changeFaultAttr
		|-> memBus.wrEn ##1 rsp_q == PWG_RSP_DONE)
		else $error("plain write not stored");
	chk_write_only: assert property (@(posedge clock) disable iff (!rstN) // R7
		!isWrite |-> !memBus.wrEn)
		else $error("store written without a write request");

	// ----------------------------------------
	// checks: port handshake
	// ----------------------------------------
	// the pulse checks lean on the grant mask of a port whose answer stands
	chk_serial_abort: assert property (@(posedge clock) disable iff (!rstN) // R3
		grantSer && refuse |=> serRsp == PWG_RSP_ABORT && canRsp == PWG_RSP_NONE)
		else $error("serial abort not reported on serial port");
	chk_can_abort: assert property (@(posedge clock) disable iff (!rstN) // R3
		grantCan && refuse |=> canRsp == PWG_RSP_ABORT && serRsp == PWG_RSP_NONE)
		else $error("CAN abort not reported on CAN port");
	chk_port_ack: assert property (@(posedge clock) disable iff (!rstN) // R1
		canReq && !serReq && !canAck |=> canAck)
		else $error("lone CAN request not served");
	chk_lone_ser: assert property (@(posedge clock) disable iff (!rstN) // R1
		serReq && !canReq && !serAck |=> serAck)
		else $error("lone serial request not served");
	chk_both_one: assert property (@(posedge clock) disable iff (!rstN) // R1
		canReq && serReq && !canAck && !serAck |=> canAck != serAck)
		else $error("contending requests not served one at a time");
	chk_idle_quiet: assert property (@(posedge clock) disable iff (!rstN) // R1
		!canReq && !serReq |=> !canAck && !serAck)
		else $error("ack given without a request");
	chk_can_pulse: assert property (@(posedge clock) disable iff (!rstN) // R1
		canAck |=> !canAck)
		else $error("CAN ack longer than one cycle");
	chk_ser_pulse: assert property (@(posedge clock) disable iff (!rstN) // R1
		serAck |=> !serAck)
		else $error("serial ack longer than one cycle");
	chk_can_rsp: assert property (@(posedge clock) disable iff (!rstN) // R8
		canAck |-> canRsp != PWG_RSP_NONE)
		else $error("CAN ack without a response code");
	chk_ser_rsp: assert property (@(posedge clock) disable iff (!rstN) // R8
		serAck |-> serRsp != PWG_RSP_NONE)
		else $error("serial ack without a response code");
endmodule : pwg_guard

// ===== rtl/pwg_param_mem.sv
// parameter store with registered read data
`timescale 1ns/10ps
`include "pwg_defs.svh"
module pwg_param_mem #(
	parameter int AW = 8,
	parameter int DW = 16
) (
	input  wire logic clock,
	pwg_mem_if.mem    port
);
	logic [DW-1:0] store [0:(1<<AW)-1];
	logic [DW-1:0] rdData_q;

	always_ff @(posedge clock) begin
		if (port.wrEn) begin
			store[port.wrAddr] <= port.wrData;
		end
		rdData_q <= store[port.rdAddr];
	end

	assign port.rdData = rdData_q;
endmodule : pwg_param_mem

// ===== testbench/pwg_requester.sv
// requester model standing in for a CAN master or a serial programmer
`timescale 1ns/10ps
module pwg_requester (
	input  wire logic              clock,
	output logic                   req,
	output logic                   write,
	output logic [7:0]             addr,
	output logic [15:0]            wrData,
	input  wire logic              ack,
	input  wire pwg_pkg::pwg_rsp_t rsp,
	input  wire logic [15:0]       rdData
);
	import pwg_pkg::*;
	initial begin
		req = 1'b0;
		write = 1'b0;
		addr = 8'h00;
		wrData = 16'h0000;
	end
	// ------------------------------
	// one whole word transfer
	// ------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
		output pwg_rsp_t r, output logic [15:0] q, output logic ok);
		@(posedge clock);
		req <= 1'b1;
		write <= w;
		addr <= a;
		wrData <= d;
		ok = 1'b0;
		for (int i = 0; i < 20 && !ok; i++) begin
			@(posedge clock);
			if (ack === 1'b1) begin
				ok = 1'b1;
				r = rsp;
				q = rdData;
			end
		end
		req <= 1'b0;
		// released lines show the inverse, so stale values cannot pass
		addr <= ~a;
		wrData <= ~d;
	endtask : xfer
endmodule : pwg_requester

// ===== testbench/tb_top.sv
// self-checking bench for the parameter write guard
`timescale 1ns/10ps
module tb_top;
	import pwg_pkg::*;
	logic        clock, nrst, cReq, cWr, sReq, sWr, cAck, sAck, fault;
	logic [3:0]  deviceState;
	logic [7:0]  cAddr, sAddr, attrAddr, faultCode;
	logic [15:0] cWd, sWd, cRd, sRd;
	pwg_rsp_t    cRsp, sRsp;
	int          nFail = 0, cmpCount = 0;
	// ------------------------------
	// attribute table and wiring
	// ------------------------------
	wire logic cfAttr = (attrAddr == 8'h10);
	wire logic ioAttr = (attrAddr == 8'h20);
	pwg_guard u_dut (.clock(clock), .nrst(nrst), .deviceState(deviceState), .canReq(cReq),
		.canWrite(cWr), .canAddr(cAddr), .canWrData(cWd), .canAck(cAck), .canRsp(cRsp),
		.canRdData(cRd), .serReq(sReq), .serWrite(sWr), .serAddr(sAddr), .serWrData(sWd),
		.serAck(sAck), .serRsp(sRsp), .serRdData(sRd), .changeFaultAttr(cfAttr),
		.idleOnlyAttr(ioAttr), .attrAddr(attrAddr), .paramChangeFault(fault),
		.faultCode(faultCode));
	pwg_requester u_can (.clock(clock), .req(cReq), .write(cWr), .addr(cAddr),
		.wrData(cWd), .ack(cAck), .rsp(cRsp), .rdData(cRd));
	pwg_requester u_ser (.clock(clock), .req(sReq), .write(sWr), .addr(sAddr),
		.wrData(sWd), .ack(sAck), .rsp(sRsp), .rdData(sRd));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nFail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task wrap_up;
		$display("fails=%0d compares=%0d", nFail, cmpCount);
		if (nFail == 0 && cmpCount > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	task op(input logic ser, input logic w, input logic [7:0] a, input logic [15:0] d,
		output pwg_rsp_t r, output logic [15:0] q);
		logic ok;
		if (ser) u_ser.xfer(w, a, d, r, q, ok);
		else u_can.xfer(w, a, d, r, q, ok);
		if (!ok) begin
			nFail++;
			wrap_up();
		end
		#1;
	endtask : op
	task testPlain;
		pwg_rsp_t r;
		logic [15:0] q;
		op(1'b0, 1'b1, 8'h05, 16'hA5C3, r, q);
		chk(16'(r), 16'(PWG_RSP_DONE));
		op(1'b1, 1'b0, 8'h05, 16'h0000, r, q);
		chk(q, 16'hA5C3);
		op(1'b1, 1'b1, 8'h06, 16'h3C5A, r, q);
		op(1'b0, 1'b0, 8'h06, 16'h0000, r, q);
		chk(q, 16'h3C5A);
		chk(16'(fault), 16'h0000);
	endtask : testPlain
	task testIdle;
		pwg_rsp_t r;
		logic [15:0] q, kept;
		logic okSt;
		for (int s = 0; s < 16; s++) begin
			@(posedge clock) deviceState <= 4'(s);
			okSt = (s == 0) || (s == 2) || (s == 3) || (s == 14);
			op(s[0], 1'b1, 8'h20, 16'h1200 + 16'(s), r, q);
			chk(16'(r), 16'(okSt ? PWG_RSP_DONE : PWG_RSP_ABORT));
			if (okSt) kept = 16'h1200 + 16'(s);
			op(~s[0], 1'b0, 8'h20, 16'h0000, r, q);
			chk(q, kept);
			chk(16'(fault), 16'h0000);
		end
		@(posedge clock) deviceState <= 4'h0;
	endtask : testIdle
	task testFault;
		pwg_rsp_t r;
		logic [15:0] q;
		op(1'b1, 1'b1, 8'h10, 16'h0007, r, q);
		chk(16'(fault), 16'h0001);
		chk(16'(faultCode), 16'h0031);
		op(1'b0, 1'b1, 8'h05, 16'h0001, r, q);
		chk(16'(faultCode), 16'h0031);
		@(posedge clock) nrst <= 1'b0;
		@(posedge clock) nrst <= 1'b1;
		repeat (4) @(posedge clock);
		#1 chk(16'(fault), 16'h0000);
		op(1'b0, 1'b1, 8'h10, 16'h0008, r, q);
		chk(16'(faultCode), 16'h0031);
	endtask : testFault
	task testBoth;
		pwg_rsp_t    rC, rS;
		logic [15:0] qC, qS;
		logic        okC, okS;
		fork
			u_can.xfer(1'b1, 8'h07, 16'h7E01, rC, qC, okC);
			u_ser.xfer(1'b1, 8'h08, 16'h8E02, rS, qS, okS);
		join
		if (!okC || !okS) begin
			nFail++;
			wrap_up();
		end
		#1;
		chk(16'(rC), 16'(PWG_RSP_DONE));
		chk(16'(rS), 16'(PWG_RSP_DONE));
		op(1'b1, 1'b0, 8'h07, 16'h0000, rC, qC);
		chk(qC, 16'h7E01);
		op(1'b0, 1'b0, 8'h08, 16'h0000, rS, qS);
		chk(qS, 16'h8E02);
	endtask : testBoth
	initial begin
		nrst = 1'b0;
		deviceState = 4'h0;
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		testPlain();
		testBoth();
		testIdle();
		testFault();
		wrap_up();
	end
endmodule : tb_top
